// ### hw/data_eeprom_access.v
// Function
// - A byte store of 1024 locations, index 000h to 3FFh, with byte reads and writes.
// - The store is reached only through this block's registers, never mapped directly.
// - The byte buffer receives read data and supplies write data.
// - The 10-bit index is split, upper two bits high register, lower eight low register.
// - The upper six bits of the high index register read as zero.
// - Every byte write erases the location first and then programs it.
// - Write length comes from an internal timer, completion only when it expires.
// - The unlock port holds nothing, reads zero, and writes only feed the unlock sequence.
// - Software can set the read and commit triggers but not clear them; hardware clears.
// - Writes need the permit bit set, and the permit bit is clear after power-up.
// - A pin reset or watchdog reset during a write sets the abort flag.
// - Reset zeroes the byte buffer and index registers; software reloads after abort.
// - Write completion sets a done flag that stays until software clears it.
`include "nvm_access_regs.vh"
module data_eeprom_access #(
    parameter WRITE_CYCLES = `WRITE_CYCLES,
    parameter ERASE_CYCLES = `ERASE_CYCLES
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        por,
    input  wire        ext_reset_pin,
    input  wire        watchdog_timeout,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         irq
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE  = 2'd0;
    localparam ST_READ  = 2'd1;
    localparam ST_ERASE = 2'd2;
    localparam ST_PROG  = 2'd3;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [7:0]  buf_q;
    reg  [7:0]  idx_lo_q;
    reg  [1:0]  idx_hi_q;
    reg         rd_trig_q;
    reg         wr_trig_q;
    reg         permit_q;
    reg         abort_q;
    reg  [1:0]  unlock_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_mask_q;
    reg  [1:0]  st_q;
    reg  [31:0] tmr_q;
    reg         ack_q;
    reg  [31:0] rd_word;
    // Reset sources after their synchronisers
    wire [2:0]  async_in;
    wire [2:0]  sync_out;
    wire        pin_rst;
    wire        wdt_rst;
    wire        por_rst;
    wire        dev_rst;
    wire [7:0]  mem_rdata;
    wire        acc;
    wire        wr_acc;
    wire        lane0;
    wire [7:0]  wbyte;
    wire        abort_ev;
    wire        done_ev;
    wire        start_wr;
    wire [9:0]  index;
    wire        start_rd;
    // Sequencer helpers
    wire        wr_busy;
    wire        tmr_zero;
    wire        erase_end;
    wire        prog_end;
    // Per-register write strobes
    wire        wr_buf;
    wire        wr_lo;
    wire        wr_hi;
    wire        wr_ctl;
    wire        wr_unl;
    wire        wr_sts;
    wire        wr_msk;

    // Decode helper for register writes
    function wr_hit;
        input [3:0] a;
        input [3:0] ofs;
        begin
            wr_hit = (a == ofs);
        end
    endfunction

    assign index  = {idx_hi_q, idx_lo_q};
    assign acc    = (avs_read | avs_write) & ~ack_q;
    assign wr_acc = avs_write & ~ack_q;
    assign lane0  = avs_byteenable[0];
    assign wbyte  = avs_writedata[7:0];

    // Register write strobes, lane 0 only
    assign wr_buf = wr_acc & lane0 & wr_hit(avs_address, `OFS_BYTE_BUFFER);
    assign wr_lo  = wr_acc & lane0 & wr_hit(avs_address, `OFS_INDEX_LOW);
    assign wr_hi  = wr_acc & lane0 & wr_hit(avs_address, `OFS_INDEX_HIGH);
    assign wr_ctl = wr_acc & lane0 & wr_hit(avs_address, `OFS_CONTROL);
    assign wr_unl = wr_acc & lane0 & wr_hit(avs_address, `OFS_UNLOCK_PORT);
    assign wr_sts = wr_acc & lane0 & wr_hit(avs_address, `OFS_IRQ_STATUS);
    assign wr_msk = wr_acc & lane0 & wr_hit(avs_address, `OFS_IRQ_MASK);

    // ----------------------------------------
    // Reset source synchronisers
    // ----------------------------------------
    assign async_in = {por, watchdog_timeout, ext_reset_pin};

    // Two flops per source before any logic looks at it
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            reg meta_q;
            reg sync_q;
            always @(posedge clk) begin
                meta_q <= async_in[gi];
                sync_q <= meta_q;
            end
            assign sync_out[gi] = sync_q;
        end
    endgenerate

    // Pin and watchdog resets hit data, index, unlock and sequencer
    assign pin_rst = sync_out[0];
    assign wdt_rst = sync_out[1];
    assign por_rst = sync_out[2];
    assign dev_rst = rst | pin_rst | wdt_rst;

    // ----------------------------------------
    // Sequencer events
    // ----------------------------------------
    assign wr_busy   = (st_q == ST_ERASE) | (st_q == ST_PROG);
    assign tmr_zero  = (tmr_q == 32'h0000_0000);
    // Pin or watchdog reset while a write runs
    assign abort_ev  = (pin_rst | wdt_rst) & wr_busy;
    // Last cycle of each phase, unless the write is being cut
    assign erase_end = (st_q == ST_ERASE) & tmr_zero & ~abort_ev;
    assign prog_end  = (st_q == ST_PROG) & tmr_zero & ~abort_ev;
    assign done_ev   = prog_end;
    // Commit accepted only with permit and fresh unlock
    assign start_wr  = wr_ctl & wbyte[`CTL_COMMIT_TRIG] & permit_q & (unlock_q == 2'd2) &
                       ~wr_trig_q & ~rd_trig_q;
    // Read taken when idle; the store answers one cycle later
    assign start_rd  = wr_ctl & wbyte[`CTL_READ_TRIG] & (st_q == ST_IDLE) &
                       ~start_wr;

    // ----------------------------------------
    // Storage array
    // ----------------------------------------
    nvm_store u_store (
        .clk   (clk),
        .rd_en (start_rd),
        .wr_en (prog_end),
        .erase (erase_end),
        .addr  (index),
        .wdata (buf_q),
        .rdata (mem_rdata)
    );

    // ----------------------------------------
    // Bus answer: one wait cycle per access
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            ack_q           <= acc;
            avs_waitrequest <= ~acc;
            if (acc & avs_read) begin
                avs_readdata <= rd_word;
            end
        end
    end

    // Read word by register number, unused bits zero
    always @* begin
        case (avs_address)
            `OFS_BYTE_BUFFER: rd_word = {24'h000000, buf_q};
            `OFS_INDEX_LOW:   rd_word = {24'h000000, idx_lo_q};
            `OFS_INDEX_HIGH:  rd_word = {30'h0, idx_hi_q};
            `OFS_CONTROL:     rd_word = {28'h0, abort_q, permit_q,
                                         wr_trig_q, rd_trig_q};
            `OFS_UNLOCK_PORT: rd_word = 32'h0000_0000;
            `OFS_IRQ_STATUS:  rd_word = {30'h0, irq_stat_q};
            `OFS_IRQ_MASK:    rd_word = {30'h0, irq_mask_q};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // Device-reset registers: data and index
    // ----------------------------------------
    always @(posedge clk) begin
        if (dev_rst) begin
            buf_q    <= `RST_BYTE;
            idx_lo_q <= `RST_BYTE;
            idx_hi_q <= 2'h0;
        end else begin
            // Store data fetched by start_rd lands here
            if (st_q == ST_READ) begin
                buf_q <= mem_rdata;
            end else if (wr_buf & ~wr_trig_q) begin
                buf_q <= wbyte;
            end
            // Index stays put while a write runs
            if (wr_lo & ~wr_trig_q) begin
                idx_lo_q <= wbyte;
            end
            if (wr_hi & ~wr_trig_q) begin
                idx_hi_q <= wbyte[1:0];
            end
        end
    end

    // ----------------------------------------
    // Control bits, unlock tracker
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst | por_rst) begin
            permit_q <= 1'b0;
            abort_q  <= 1'b0;
        end else begin
            // A cut write beats a software write of the flag
            if (abort_ev) begin
                abort_q <= 1'b1;
            end else if (wr_ctl) begin
                abort_q <= wbyte[`CTL_ABORT];
            end
            if (wr_ctl) begin
                permit_q <= wbyte[`CTL_PERMIT];
            end
        end
    end

    // Two keys in sequence; any other access breaks it
    always @(posedge clk) begin
        if (dev_rst) begin
            unlock_q <= 2'd0;
        end else if (wr_unl) begin
            if (wbyte == `UNLOCK_KEY_A) begin
                unlock_q <= 2'd1;
            end else if ((wbyte == `UNLOCK_KEY_B) & (unlock_q == 2'd1)) begin
                unlock_q <= 2'd2;
            end else begin
                unlock_q <= 2'd0;
            end
        end else if (acc) begin
            unlock_q <= 2'd0;
        end
    end

    // ----------------------------------------
    // Sequencer: read, erase, program
    // ----------------------------------------
    always @(posedge clk) begin
        if (dev_rst) begin
            st_q      <= ST_IDLE;
            tmr_q     <= 32'd0;
            rd_trig_q <= 1'b0;
            wr_trig_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (start_wr) begin
                        wr_trig_q <= 1'b1;
                        st_q      <= ST_ERASE;
                        tmr_q     <= ERASE_CYCLES - 1;
                    end else if (start_rd) begin
                        rd_trig_q <= 1'b1;
                        st_q      <= ST_READ;
                    end
                end
                ST_READ: begin
                    rd_trig_q <= 1'b0;
                    st_q      <= ST_IDLE;
                end
                ST_ERASE: begin
                    if (tmr_q == 32'd0) begin
                        st_q  <= ST_PROG;
                        tmr_q <= WRITE_CYCLES - ERASE_CYCLES - 1;
                    end else begin
                        tmr_q <= tmr_q - 32'd1;
                    end
                end
                ST_PROG: begin
                    if (tmr_q == 32'd0) begin
                        wr_trig_q <= 1'b0;
                        st_q      <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 32'd1;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Sticky events, write-one-to-clear, mask
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
        end else begin
            // Set beats clear in the same cycle
            if (done_ev) begin
                irq_stat_q[`IRQ_DONE] <= 1'b1;
            end else if (wr_sts & wbyte[`IRQ_DONE]) begin
                irq_stat_q[`IRQ_DONE] <= 1'b0;
            end
            if (abort_ev) begin
                irq_stat_q[`IRQ_ABORT] <= 1'b1;
            end else if (wr_sts & wbyte[`IRQ_ABORT]) begin
                irq_stat_q[`IRQ_ABORT] <= 1'b0;
            end
            if (wr_msk) begin
                irq_mask_q <= wbyte[1:0];
            end
        end
    end

    // Level request, one cycle behind status and mask
    always @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule

// ### hw/nvm_access_regs.vh
`ifndef NVM_ACCESS_REGS_VH
`define NVM_ACCESS_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFS_BYTE_BUFFER  4'h0
`define OFS_INDEX_LOW    4'h1
`define OFS_INDEX_HIGH   4'h2
`define OFS_CONTROL      4'h3
`define OFS_UNLOCK_PORT  4'h4
`define OFS_IRQ_STATUS   4'h5
`define OFS_IRQ_MASK     4'h6
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_READ_TRIG    0
`define CTL_COMMIT_TRIG  1
`define CTL_PERMIT       2
`define CTL_ABORT        3
// ----------------------------------------
// Status / mask fields
// ----------------------------------------
`define IRQ_DONE         0
`define IRQ_ABORT        1
// ----------------------------------------
// Reset values and unlock keys
// ----------------------------------------
`define RST_BYTE         8'h00
`define UNLOCK_KEY_A     8'h55
`define UNLOCK_KEY_B     8'haa
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    10
`define WRITE_TIME_US    4000
`define WRITE_CYCLES     ((`WRITE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define ERASE_CYCLES     (`WRITE_CYCLES / 2)
`endif

// ### hw/nvm_store.v
// ----------------------------------------
// Byte-wide array of 1024 locations
// ----------------------------------------
module nvm_store (
    input  wire       clk,
    input  wire       rd_en,
    input  wire       wr_en,
    input  wire       erase,
    input  wire [9:0] addr,
    input  wire [7:0] wdata,
    output reg  [7:0] rdata
);
    reg [7:0] mem [0:1023];

    // Erase drives all ones, program overwrites
    always @(posedge clk) begin
        if (erase) begin
            mem[addr] <= 8'hff;
        end else if (wr_en) begin
            mem[addr] <= wdata;
        end
        if (rd_en) begin
            rdata <= mem[addr];
        end
    end
endmodule

// ### tb/nvm_access_checker.sv
`include "nvm_access_regs.vh"
module nvm_access_checker (
    input logic        clk,
    input logic        rst,
    input logic [3:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic        irq
);
    // ----------------------------------------
    // Bus answer timing and read values
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ack_after_req_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    ack_one_cycle_a: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest)
        else $error("write answer shape wrong");
    ack_needs_req_a: assert property (!avs_waitrequest |-> (avs_read || avs_write) && $past(avs_read || avs_write))
        else $error("answer without request");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > `OFS_IRQ_MASK |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    unlock_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == `OFS_UNLOCK_PORT |-> avs_readdata == 32'h0)
        else $error("unlock port read not zero");
    high_index_a: assert property (avs_read && !avs_waitrequest && avs_address == `OFS_INDEX_HIGH |-> avs_readdata[31:2] == 30'h0)
        else $error("high index upper bits set");
    lane_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data above byte set");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without read");
    // Main scenarios reached
    irq_seen_c: cover property ($rose(irq));
    unlock_wr_c: cover property (avs_write && !avs_waitrequest && avs_address == `OFS_UNLOCK_PORT);
    high_rd_c: cover property (avs_read && !avs_waitrequest && avs_address == `OFS_INDEX_HIGH);
endmodule
bind data_eeprom_access nvm_access_checker u_nvm_access_checker (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// ### tb/data_eeprom_access_tb.sv
`include "nvm_access_regs.vh"
module data_eeprom_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        por = 1'b0;
    logic        ext_reset_pin = 1'b0;
    logic        watchdog_timeout = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    wire         irq;
    integer      error_cnt = 0;
    integer      cmp_count = 0;
    integer      cyc = 0;
    integer      n;
    integer      k;
    logic [31:0] q;
    logic [9:0]  a;
    logic [7:0]  d;
    logic [7:0]  mem [0:1023];  // Model of the store
    // ----------------------------------------
    // Design, clock, run limit
    // ----------------------------------------
    data_eeprom_access #(.WRITE_CYCLES(20), .ERASE_CYCLES(10)) u_data_eeprom_access (
        .clk(clk), .rst(rst), .por(por), .ext_reset_pin(ext_reset_pin),
        .watchdog_timeout(watchdog_timeout), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            give_verdict;
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task give_verdict;
        begin
            $display("compares %0d mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task bus(input logic rd, input logic [3:0] adr, input logic [7:0] dat);
        integer w;
        begin
            w = 0;
            avs_address   <= adr;
            avs_writedata <= {24'h0, dat};
            avs_read      <= rd;
            avs_write     <= ~rd;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) begin
                @(posedge clk);
                w = w + 1;
            end
            chk(w, 32'h1);
            q = avs_readdata;
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clk);
        end
    endtask
    task commit(input logic [9:0] ad, input logic [7:0] dv, input logic [7:0] ctl);
        begin
            bus(1'b0, `OFS_INDEX_HIGH, {6'h0, ad[9:8]});
            bus(1'b0, `OFS_INDEX_LOW, ad[7:0]);
            bus(1'b0, `OFS_BYTE_BUFFER, dv);
            bus(1'b0, `OFS_UNLOCK_PORT, `UNLOCK_KEY_A);
            bus(1'b0, `OFS_UNLOCK_PORT, `UNLOCK_KEY_B);
            bus(1'b0, `OFS_CONTROL, ctl);
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(53537));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 7; k = k + 1) begin
            bus(1'b1, k[3:0], 8'h00);
            chk(q, 32'h0);
        end
        $display("test reset values done");
        d = 8'($urandom());
        bus(1'b0, `OFS_INDEX_HIGH, d);
        bus(1'b1, `OFS_INDEX_HIGH, 8'h00);
        chk(q, {30'h0, d[1:0]});
        bus(1'b0, `OFS_UNLOCK_PORT, d);
        bus(1'b1, `OFS_UNLOCK_PORT, 8'h00);
        chk(q, 32'h0);
        bus(1'b0, 4'h9, d);
        bus(1'b1, 4'h9, 8'h00);
        chk(q, 32'h0);
        bus(1'b0, `OFS_INDEX_LOW, d);
        avs_byteenable <= 4'he;
        bus(1'b0, `OFS_INDEX_LOW, ~d);
        avs_byteenable <= 4'hf;
        bus(1'b1, `OFS_INDEX_LOW, 8'h00);
        chk(q, {24'h0, d});
        bus(1'b0, `OFS_CONTROL, 8'h04);
        bus(1'b0, `OFS_CONTROL, 8'h06);
        bus(1'b1, `OFS_CONTROL, 8'h00);
        chk(q[2:1], 2'b10);
        $display("test registers done");
        // Writes: both ends of the range, then an overwrite
        for (n = 0; n < 4; n = n + 1) begin
            a = (n == 0) ? 10'h000 : (n == 1) ? 10'h3ff : (n == 3) ? a : 10'($urandom());
            d = 8'($urandom());
            commit(a, d, 8'h06);
            bus(1'b1, `OFS_CONTROL, 8'h00);
            chk(q[1], 1'b1);
            bus(1'b0, `OFS_CONTROL, 8'h04);
            bus(1'b0, `OFS_BYTE_BUFFER, ~d);
            bus(1'b1, `OFS_CONTROL, 8'h00);
            chk(q[1], 1'b1);
            k = 0;
            q = 32'h0;
            while (q[0] !== 1'b1 && k < 40) begin
                bus(1'b1, `OFS_IRQ_STATUS, 8'h00);
                k = k + 1;
            end
            chk(k >= 2 && k <= 4, 1'b1);
            chk(q[1:0], 2'b01);
            mem[a] = d;
            bus(1'b1, `OFS_CONTROL, 8'h00);
            chk(q[1:0], 2'b00);
            bus(1'b1, `OFS_BYTE_BUFFER, 8'h00);
            chk(q, {24'h0, d});
            chk(irq, 1'b0);
            bus(1'b0, `OFS_IRQ_MASK, 8'h01);
            repeat (2) @(posedge clk);
            chk(irq, 1'b1);
            bus(1'b0, `OFS_IRQ_STATUS, 8'h01);
            repeat (2) @(posedge clk);
            chk(irq, 1'b0);
            bus(1'b0, `OFS_IRQ_MASK, 8'h00);
            bus(1'b0, `OFS_BYTE_BUFFER, ~d);
            bus(1'b0, `OFS_CONTROL, 8'h05);
            repeat (3) @(posedge clk);
            bus(1'b1, `OFS_BYTE_BUFFER, 8'h00);
            chk(q, {24'h0, mem[a]});
            bus(1'b1, `OFS_CONTROL, 8'h00);
            chk(q[0], 1'b0);
        end
        $display("test writes done");
        // Pin reset, then watchdog, in mid-write
        for (n = 0; n < 2; n = n + 1) begin
            commit(10'($urandom()), 8'($urandom()), 8'h06);
            if (n == 0) ext_reset_pin <= 1'b1;
            else watchdog_timeout <= 1'b1;
            repeat (4) @(posedge clk);
            ext_reset_pin    <= 1'b0;
            watchdog_timeout <= 1'b0;
            repeat (6) @(posedge clk);
            bus(1'b1, `OFS_CONTROL, 8'h00);
            chk(q[3:1], 3'b110);
            bus(1'b1, `OFS_IRQ_STATUS, 8'h00);
            chk(q[1], 1'b1);
            for (k = 0; k < 3; k = k + 1) begin
                bus(1'b1, k[3:0], 8'h00);
                chk(q, 32'h0);
            end
            bus(1'b0, `OFS_IRQ_STATUS, 8'h02);
            bus(1'b0, `OFS_CONTROL, 8'h04);
            bus(1'b1, `OFS_CONTROL, 8'h00);
            chk(q[3], 1'b0);
        end
        $display("test aborts done");
        por <= 1'b1;
        repeat (4) @(posedge clk);
        por <= 1'b0;
        repeat (6) @(posedge clk);
        bus(1'b1, `OFS_CONTROL, 8'h00);
        chk(q[2], 1'b0);
        commit(10'h005, 8'h5a, 8'h02);
        bus(1'b1, `OFS_CONTROL, 8'h00);
        chk(q[1], 1'b0);
        $display("test power-up done");
        give_verdict;
    end
endmodule
